// ---- hdl/aps_top.v ----
`timescale 1ns/10ps
`include "aps_map.vh"
// Operation
// - preset edge loads signed value into position
// - axis operand 0 is x, 1 is y
// - other axis value sets operand error only
// - accepted preset marks origin fixed
// - preset while moving rejected, error 451
// - emergency stop halts output, flags stop, 481
// - after stop keep inhibit, origin undecided
// - clear edge clears error; nonzero value releases inhibit
module aps_top #(
  parameter AW    = 8,
  parameter POS_W = 32
) (
  // clock and reset
  input  wire          aclk,
  input  wire          aresetn,
  // axi4-lite write address and data
  input  wire [AW-1:0] s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output wire          s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output wire          s_axi_wready,
  // axi4-lite write response
  output wire [1:0]    s_axi_bresp,
  output wire          s_axi_bvalid,
  input  wire          s_axi_bready,
  // axi4-lite read
  input  wire [AW-1:0] s_axi_araddr,
  input  wire          s_axi_arvalid,
  output wire          s_axi_arready,
  output wire [31:0]   s_axi_rdata,
  output wire [1:0]    s_axi_rresp,
  output wire          s_axi_rvalid,
  input  wire          s_axi_rready,
  // pulse generator feedback, x axis
  input  wire          x_busy,
  input  wire          x_step,
  input  wire          x_dir,
  // pulse generator feedback, y axis
  input  wire          y_busy,
  input  wire          y_step,
  input  wire          y_dir,
  // status flags
  output wire          x_origin_fixed_flag,
  output wire          y_origin_fixed_flag,
  output wire          x_output_stop_flag,
  output wire          y_output_stop_flag,
  output reg           operand_error_flag,
  // interrupt
  output reg           irq
);
  wire          wr_go;
  wire [AW-1:0] wr_addr;
  wire [31:0]   wr_data;
  wire [3:0]    wr_strb;
  wire [AW-1:0] rd_addr;
  reg  [31:0]   rd_data;

  reg  [`APS_CMD_W-1:0]  cmd_q;
  reg  [`APS_CMD_W-1:0]  cmd_prev_q;
  reg  [`APS_OPND_W-1:0] axis_select_operand_q;
  reg  [`APS_OPND_W-1:0] slot_operand_q;
  reg  [POS_W-1:0]       value_operand_q;
  reg  [`APS_IRQ_W-1:0]  irq_st_q;
  reg  [`APS_IRQ_W-1:0]  irq_st_d;
  reg  [`APS_IRQ_W-1:0]  irq_mask_q;

  wire [`APS_CMD_W-1:0]  cmd_edge;
  wire                   any_edge;
  wire                   axis_ok;
  wire [1:0]             axis_hit;
  wire [2*POS_W-1:0]     pos_w;
  wire [1:0]             org_w;
  wire [1:0]             stop_w;
  wire [2*`APS_ERR_W-1:0] err_w;
  wire [1:0]             stop_ev_w;
  wire [1:0]             rej_ev_w;
  wire [1:0]             busy_w;
  wire [1:0]             step_w;
  wire [1:0]             dir_w;
  wire [31:0]            cmd_mrg;
  wire [31:0]            axis_mrg;
  wire [31:0]            slot_mrg;
  wire [31:0]            mask_mrg;
  wire [31:0]            w1c_mrg;

  ////////////////////////////////////////////////////////////////////////
  // address decode, shared by the read and write paths
  function addr_hit;
    input [AW-1:0] a;
    begin
      if (a == `APS_CMD_OFS) addr_hit = 1'b1;
      else if (a == `APS_AXIS_OFS) addr_hit = 1'b1;
      else if (a == `APS_SLOT_OFS) addr_hit = 1'b1;
      else if (a == `APS_VALUE_OFS) addr_hit = 1'b1;
      else if (a == `APS_STATUS_OFS) addr_hit = 1'b1;
      else if (a == `APS_XPOS_OFS) addr_hit = 1'b1;
      else if (a == `APS_YPOS_OFS) addr_hit = 1'b1;
      else if (a == `APS_XERR_OFS) addr_hit = 1'b1;
      else if (a == `APS_YERR_OFS) addr_hit = 1'b1;
      else if (a == `APS_IRQ_ST_OFS) addr_hit = 1'b1;
      else if (a == `APS_IRQ_MASK_OFS) addr_hit = 1'b1;
      else addr_hit = 1'b0;
    end
  endfunction

  // byte-lane merge of a write into an old word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) merge[8*k +: 8] = nw[8*k +: 8];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // bus slave
  aps_axil #(
    .AW (AW)
  ) u_axil (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .wr_go   (wr_go),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (addr_hit(wr_addr)),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_ok   (addr_hit(rd_addr))
  );

  ////////////////////////////////////////////////////////////////////////
  // byte-lane merges, cut back to each register's width on purpose
  assign cmd_mrg  = merge({29'h0, cmd_q}, wr_data, wr_strb);
  assign axis_mrg = merge({16'h0, axis_select_operand_q}, wr_data, wr_strb);
  assign slot_mrg = merge({16'h0, slot_operand_q}, wr_data, wr_strb);
  assign mask_mrg = merge({27'h0, irq_mask_q}, wr_data, wr_strb);
  assign w1c_mrg  = merge(32'h0000_0000, wr_data, wr_strb);

  // writable registers; trigger bits are levels, commands act on their rising edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      cmd_q                 <= {`APS_CMD_W{1'b0}};
      cmd_prev_q            <= {`APS_CMD_W{1'b0}};
      axis_select_operand_q <= `APS_AXIS_X;
      slot_operand_q        <= {`APS_OPND_W{1'b0}};
      value_operand_q       <= `APS_POS_RST;
      irq_mask_q            <= {`APS_IRQ_W{1'b0}};
    end else begin
      cmd_prev_q <= cmd_q;
      if (wr_go) begin
        if (wr_addr == `APS_CMD_OFS) begin
          cmd_q <= cmd_mrg[`APS_CMD_W-1:0];
        end else if (wr_addr == `APS_AXIS_OFS) begin
          axis_select_operand_q <= axis_mrg[`APS_OPND_W-1:0];
        end else if (wr_addr == `APS_SLOT_OFS) begin
          // kept for readback only: the built-in unit answers on slot zero
          slot_operand_q <= slot_mrg[`APS_OPND_W-1:0];
        end else if (wr_addr == `APS_VALUE_OFS) begin
          value_operand_q <= merge(value_operand_q, wr_data, wr_strb);
        end else if (wr_addr == `APS_IRQ_MASK_OFS) begin
          irq_mask_q <= mask_mrg[`APS_IRQ_W-1:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command decode: an invalid axis reaches neither axis
  assign cmd_edge    = cmd_q & ~cmd_prev_q;
  assign any_edge    = |cmd_edge;
  assign axis_ok     = (axis_select_operand_q == `APS_AXIS_X) ||
                       (axis_select_operand_q == `APS_AXIS_Y);
  assign axis_hit[0] = axis_select_operand_q == `APS_AXIS_X;
  assign axis_hit[1] = axis_select_operand_q == `APS_AXIS_Y;
  assign busy_w      = {y_busy, x_busy};
  assign step_w      = {y_step, x_step};
  assign dir_w       = {y_dir, x_dir};

  // one axis instance each; commands are gated by that axis's own select
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_axis
      aps_axis #(
        .POS_W (POS_W)
      ) u_axis (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .preset_go      (cmd_edge[`APS_CMD_PRESET] & axis_hit[i]),
        .stop_go        (cmd_edge[`APS_CMD_STOP] & axis_hit[i]),
        .clear_go       (cmd_edge[`APS_CMD_CLEAR] & axis_hit[i]),
        .value_operand  (value_operand_q),
        .busy           (busy_w[i]),
        .step           (step_w[i]),
        .dir            (dir_w[i]),
        .pos_q          (pos_w[i*POS_W +: POS_W]),
        .origin_fixed_q (org_w[i]),
        .output_stop_q  (stop_w[i]),
        .err_q          (err_w[i*`APS_ERR_W +: `APS_ERR_W]),
        .stop_ev_q      (stop_ev_w[i]),
        .rej_ev_q       (rej_ev_w[i])
      );
    end
  endgenerate

  assign x_origin_fixed_flag = org_w[0];
  assign y_origin_fixed_flag = org_w[1];
  assign x_output_stop_flag  = stop_w[0];
  assign y_output_stop_flag  = stop_w[1];

  ////////////////////////////////////////////////////////////////////////
  // operand error: set by a command with a bad axis, cleared by a good one
  always @(posedge aclk) begin
    if (!aresetn) begin
      operand_error_flag <= 1'b0;
    end else if (any_edge) begin
      operand_error_flag <= ~axis_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky interrupt status, write one to clear; a new event beats the clear
  always @* begin
    irq_st_d = irq_st_q;
    if (wr_go && wr_addr == `APS_IRQ_ST_OFS) begin
      irq_st_d = irq_st_q & ~w1c_mrg[`APS_IRQ_W-1:0];
    end
    irq_st_d[`APS_IRQ_OPERR] = irq_st_d[`APS_IRQ_OPERR] | (any_edge & ~axis_ok);
    irq_st_d[`APS_IRQ_XSTOP] = irq_st_d[`APS_IRQ_XSTOP] | stop_ev_w[0];
    irq_st_d[`APS_IRQ_YSTOP] = irq_st_d[`APS_IRQ_YSTOP] | stop_ev_w[1];
    irq_st_d[`APS_IRQ_XREJ]  = irq_st_d[`APS_IRQ_XREJ] | rej_ev_w[0];
    irq_st_d[`APS_IRQ_YREJ]  = irq_st_d[`APS_IRQ_YREJ] | rej_ev_w[1];
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_st_q <= {`APS_IRQ_W{1'b0}};
      irq      <= 1'b0;
    end else begin
      irq_st_q <= irq_st_d;
      irq      <= |(irq_st_q & irq_mask_q); // one cycle behind status, kept as a flop
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux; unmapped addresses are answered by the slave with slverr
  always @* begin
    rd_data = 32'h0000_0000;
    if (rd_addr == `APS_CMD_OFS) begin
      rd_data = {29'h0, cmd_q};
    end else if (rd_addr == `APS_AXIS_OFS) begin
      rd_data = {16'h0, axis_select_operand_q};
    end else if (rd_addr == `APS_SLOT_OFS) begin
      rd_data = {16'h0, slot_operand_q};
    end else if (rd_addr == `APS_VALUE_OFS) begin
      rd_data = value_operand_q;
    end else if (rd_addr == `APS_STATUS_OFS) begin
      rd_data = {27'h0, stop_w[1], stop_w[0], org_w[1], org_w[0], operand_error_flag};
    end else if (rd_addr == `APS_XPOS_OFS) begin
      rd_data = pos_w[0 +: POS_W];
    end else if (rd_addr == `APS_YPOS_OFS) begin
      rd_data = pos_w[POS_W +: POS_W];
    end else if (rd_addr == `APS_XERR_OFS) begin
      rd_data = {16'h0, err_w[0 +: `APS_ERR_W]};
    end else if (rd_addr == `APS_YERR_OFS) begin
      rd_data = {16'h0, err_w[`APS_ERR_W +: `APS_ERR_W]};
    end else if (rd_addr == `APS_IRQ_ST_OFS) begin
      rd_data = {27'h0, irq_st_q};
    end else if (rd_addr == `APS_IRQ_MASK_OFS) begin
      rd_data = {27'h0, irq_mask_q};
    end
  end
endmodule

// ---- pkg/aps_map.vh ----
`ifndef APS_MAP_VH
`define APS_MAP_VH
// register byte offsets
`define APS_CMD_OFS      8'h00
`define APS_AXIS_OFS     8'h04
`define APS_SLOT_OFS     8'h08
`define APS_VALUE_OFS    8'h0c
`define APS_STATUS_OFS   8'h10
`define APS_XPOS_OFS     8'h14
`define APS_YPOS_OFS     8'h18
`define APS_XERR_OFS     8'h1c
`define APS_YERR_OFS     8'h20
`define APS_IRQ_ST_OFS   8'h24
`define APS_IRQ_MASK_OFS 8'h28
// command register trigger bits
`define APS_CMD_PRESET   0
`define APS_CMD_STOP     1
`define APS_CMD_CLEAR    2
`define APS_CMD_W        3
// status register bits
`define APS_ST_OPERR     0
`define APS_ST_XORG      1
`define APS_ST_YORG      2
`define APS_ST_XSTOP     3
`define APS_ST_YSTOP     4
// interrupt status and mask bits
`define APS_IRQ_OPERR    0
`define APS_IRQ_XSTOP    1
`define APS_IRQ_YSTOP    2
`define APS_IRQ_XREJ     3
`define APS_IRQ_YREJ     4
`define APS_IRQ_W        5
// operand encodings and widths
`define APS_OPND_W       16
`define APS_AXIS_X       16'h0000
`define APS_AXIS_Y       16'h0001
// axis error codes
`define APS_ERR_W        16
`define APS_ERR_NONE     16'h0000
`define APS_ERR_BUSY     16'd451
`define APS_ERR_STOP     16'd481
// reset values
`define APS_POS_RST      32'h0000_0000
// bus responses
`define APS_RESP_OKAY    2'h0
`define APS_RESP_SLVERR  2'h2
`endif

// ---- hdl/aps_axil.v ----
`timescale 1ns/10ps
`include "aps_map.vh"
// axi4-lite slave front end: one write and one read under way at a time
module aps_axil #(
  parameter AW = 8
) (
  // clock and reset
  input  wire          aclk,
  input  wire          aresetn,
  // write address and data
  input  wire [AW-1:0] awaddr,
  input  wire          awvalid,
  output reg           awready,
  input  wire [31:0]   wdata,
  input  wire [3:0]    wstrb,
  input  wire          wvalid,
  output reg           wready,
  // write response
  output reg  [1:0]    bresp,
  output reg           bvalid,
  input  wire          bready,
  // read channels
  input  wire [AW-1:0] araddr,
  input  wire          arvalid,
  output reg           arready,
  output reg  [31:0]   rdata,
  output reg  [1:0]    rresp,
  output reg           rvalid,
  input  wire          rready,
  // register file side
  output wire          wr_go,
  output reg  [AW-1:0] wr_addr,
  output reg  [31:0]   wr_data,
  output reg  [3:0]    wr_strb,
  input  wire          wr_ok,
  output reg  [AW-1:0] rd_addr,
  input  wire [31:0]   rd_data,
  input  wire          rd_ok
);
  reg rd_pend_q;

  // a write fires once both halves are held and the last response is gone
  assign wr_go = ~awready & ~wready & ~bvalid;

  ////////////////////////////////////////////////////////////////////////
  // write path: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= `APS_RESP_OKAY;
      wr_addr <= {AW{1'b0}};
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        wready  <= 1'b0;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (wr_go) begin
        bvalid  <= 1'b1;
        bresp   <= wr_ok ? `APS_RESP_OKAY : `APS_RESP_SLVERR;
        awready <= 1'b1;
        wready  <= 1'b1;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path: address captured, data registered one edge later
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready   <= 1'b1;
      rd_pend_q <= 1'b0;
      rvalid    <= 1'b0;
      rresp     <= `APS_RESP_OKAY;
      rdata     <= 32'h0000_0000;
      rd_addr   <= {AW{1'b0}};
    end else begin
      if (arvalid && arready) begin
        arready   <= 1'b0;
        rd_addr   <= araddr;
        rd_pend_q <= 1'b1;
      end
      if (rd_pend_q) begin
        rd_pend_q <= 1'b0;
        rvalid    <= 1'b1;
        rdata     <= rd_ok ? rd_data : 32'h0000_0000;
        rresp     <= rd_ok ? `APS_RESP_OKAY : `APS_RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule

// ---- hdl/aps_axis.v ----
`timescale 1ns/10ps
`include "aps_map.vh"
// state of one positioning axis: position, origin, output stop, error code
module aps_axis #(
  parameter POS_W = 32
) (
  // clock and reset
  input  wire             aclk,
  input  wire             aresetn,
  // decoded commands for this axis only
  input  wire             preset_go,
  input  wire             stop_go,
  input  wire             clear_go,
  input  wire [POS_W-1:0] value_operand,
  // pulse generator feedback
  input  wire             busy,
  input  wire             step,
  input  wire             dir,
  // state
  output reg  [POS_W-1:0] pos_q,
  output reg              origin_fixed_q,
  output reg              output_stop_q,
  output reg  [`APS_ERR_W-1:0] err_q,
  output reg              stop_ev_q,
  output reg              rej_ev_q
);
  ////////////////////////////////////////////////////////////////////////
  // emergency stop wins over a preset or clear arriving in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      pos_q          <= `APS_POS_RST;
      origin_fixed_q <= 1'b0;
      output_stop_q  <= 1'b0;
      err_q          <= `APS_ERR_NONE;
      stop_ev_q      <= 1'b0;
      rej_ev_q       <= 1'b0;
    end else begin
      stop_ev_q <= 1'b0;
      rej_ev_q  <= 1'b0;
      if (stop_go) begin
        output_stop_q  <= 1'b1;
        err_q          <= `APS_ERR_STOP;
        origin_fixed_q <= 1'b0;
        stop_ev_q      <= 1'b1;
      end else if (preset_go) begin
        if (busy) begin
          err_q    <= `APS_ERR_BUSY;
          rej_ev_q <= 1'b1;
        end else begin
          pos_q          <= value_operand;
          origin_fixed_q <= 1'b1;
        end
      end else if (clear_go) begin
        err_q <= `APS_ERR_NONE;
        if (value_operand != {POS_W{1'b0}}) begin
          output_stop_q <= 1'b0;
        end
      end else if (step && !output_stop_q) begin
        // steps are dropped while inhibited so a late pulse cannot move the count
        pos_q <= dir ? pos_q - 1'b1 : pos_q + 1'b1;
      end
    end
  end
endmodule

// ---- sim/aps_pulse_model.sv ----
`timescale 1ns/10ps
// pulse generator stand-in: busy while asked to run and not inhibited,
// one step every PER cycles, so PER sets how promptly the axis moves
module aps_pulse_model #(
  parameter PER  = 4,
  parameter DOWN = 0
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // run request and output inhibit
  input  wire logic run,
  input  wire logic halt,
  // feedback to the block
  output logic      busy,
  output logic      step,
  output logic      dir
);
  logic [15:0] cnt_q;
  logic        busy_q;
  logic        step_q;
  // an inhibited axis drops motion at once, as the real generator does
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q <= 1'b0;
      step_q <= 1'b0;
      cnt_q  <= 16'h0;
    end else begin
      busy_q <= run && !halt;
      step_q <= busy_q && !halt && cnt_q == 16'(PER - 1);
      cnt_q  <= (busy_q && cnt_q != 16'(PER - 1)) ? cnt_q + 16'h1 : 16'h0;
    end
  end
  assign busy = busy_q;
  assign step = step_q;
  assign dir  = (DOWN != 0);
endmodule

// ---- sim/aps_checker.sv ----
`timescale 1ns/10ps
module aps_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // axis feedback and flags
  input wire logic x_busy,
  input wire logic x_origin_fixed_flag,
  input wire logic y_origin_fixed_flag,
  input wire logic x_output_stop_flag,
  input wire logic y_output_stop_flag,
  input wire logic operand_error_flag,
  input wire logic irq
);
  logic run_q;
  // edge functions look one sample back, so skip the first edge after reset
  always_ff @(posedge aclk) run_q <= aresetn;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////
  aw_refuse_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address taken twice");
  ar_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    !s_axi_arready ##[0:3] s_axi_rvalid) else $error("read answer late");
  stop_one_axis_a: assert property (
    run_q && $changed(x_output_stop_flag) |-> $stable(y_output_stop_flag))
    else $error("stop flags moved together");
  origin_one_axis_a: assert property (
    run_q && $changed(x_origin_fixed_flag) |-> $stable(y_origin_fixed_flag))
    else $error("origin flags moved together");
  bad_axis_quiet_a: assert property (run_q && $rose(operand_error_flag) |->
    $stable({x_origin_fixed_flag, y_origin_fixed_flag, x_output_stop_flag, y_output_stop_flag}))
    else $error("bad axis touched an axis");
  stop_x_origin_a: assert property ($rose(x_output_stop_flag) |-> !x_origin_fixed_flag)
    else $error("x origin kept after stop");
  stop_y_origin_a: assert property ($rose(y_output_stop_flag) |-> !y_origin_fixed_flag)
    else $error("y origin kept after stop");
  clear_release_a: assert property (
    run_q && $fell(y_output_stop_flag) |-> !operand_error_flag)
    else $error("inhibit freed by bad command");
  preset_origin_a: assert property ($rose(x_origin_fixed_flag) |-> !$past(x_busy))
    else $error("origin fixed while moving");
  ////////////////////////////////////////////////////////////////////////
  cover property ($rose(x_output_stop_flag));
  cover property ($rose(operand_error_flag));
  cover property ($rose(irq));
endmodule

bind aps_top aps_checker u_chk (.*);

// ---- sim/tb_axis_preset_and_emergency_stop.sv ----
`timescale 1ns/10ps
`include "aps_map.vh"
module tb_axis_preset_and_emergency_stop;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, x_run, y_run;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         x_busy, x_step, x_dir, y_busy, y_step, y_dir, irq, operand_error_flag;
  wire         x_origin_fixed_flag, y_origin_fixed_flag, x_output_stop_flag, y_output_stop_flag;
  int          error_cnt, checked;
  aps_top u_dut (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready, .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(rready), .x_busy, .x_step, .x_dir,
    .y_busy, .y_step, .y_dir, .x_origin_fixed_flag, .y_origin_fixed_flag,
    .x_output_stop_flag, .y_output_stop_flag, .operand_error_flag, .irq);
  // x is slow so a refused preset is seen before any step lands
  aps_pulse_model #(.PER(1000)) u_xgen (.aclk, .aresetn, .run(x_run),
    .halt(x_output_stop_flag), .busy(x_busy), .step(x_step), .dir(x_dir));
  aps_pulse_model #(.PER(2), .DOWN(1)) u_ygen (.aclk, .aresetn, .run(y_run),
    .halt(y_output_stop_flag), .busy(y_busy), .step(y_step), .dir(y_dir));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // every wait is bounded; a hung handshake ends the run
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int   n;
    logic dn;
    n = 0;
    dn = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!dn && n < 50) begin
      @(posedge aclk);
      n++;
      if (awvalid && s_axi_awready) awvalid <= 1'b0;
      if (wvalid && s_axi_wready) wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        dn = 1'b1;
        bready <= 1'b0;
        chk("bresp", s_axi_bresp, er);
      end
    end
    @(posedge aclk);
    if (!dn) begin
      error_cnt++;
      summarize();
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int   n;
    logic dn;
    n = 0;
    dn = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!dn && n < 50) begin
      @(posedge aclk);
      n++;
      if (arvalid && s_axi_arready) arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        dn = 1'b1;
        rready <= 1'b0;
        d = s_axi_rdata;
        chk("rresp", s_axi_rresp, er);
      end
    end
    @(posedge aclk);
    if (!dn) begin
      error_cnt++;
      summarize();
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] d;
    rd(a, d, `APS_RESP_OKAY);
    chk(n, d, e);
  endtask
  // command bits act on a rising level, so each one is raised then dropped
  task automatic cmd(input logic [15:0] sel, input logic [31:0] v, input int b);
    wr(`APS_AXIS_OFS, {16'h0, sel}, `APS_RESP_OKAY);
    wr(`APS_VALUE_OFS, v, `APS_RESP_OKAY);
    wr(`APS_CMD_OFS, 32'h1 << b, `APS_RESP_OKAY);
    wr(`APS_CMD_OFS, 32'h0, `APS_RESP_OKAY);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int a = 'h10; a <= 'h28; a += 4) rdchk(8'(a), 32'h0, "reset value");
    $display("reset test done");
  endtask
  task automatic t_preset();
    logic [31:0] v [2];
    v[0] = 32'h8000_0000;
    v[1] = 32'h7fff_ffff;
    for (int i = 0; i < 2; i++) begin
      cmd(16'(i), v[i], `APS_CMD_PRESET);
      rdchk(`APS_XPOS_OFS + 8'(4 * i), v[i], "pos");
    end
    rdchk(`APS_XPOS_OFS, v[0], "xpos kept");
    chk("x origin", x_origin_fixed_flag, 1'b1);
    chk("y origin", y_origin_fixed_flag, 1'b1);
    $display("preset test done");
  endtask
  task automatic t_busy();
    x_run <= 1'b1;
    repeat (3) @(posedge aclk);
    cmd(16'h0, 32'h1234_5678, `APS_CMD_PRESET);
    rdchk(`APS_XERR_OFS, `APS_ERR_BUSY, "xerr");
    rdchk(`APS_XPOS_OFS, 32'h8000_0000, "xpos");
    chk("irq masked", irq, 1'b0);
    wr(`APS_IRQ_MASK_OFS, 32'h8, `APS_RESP_OKAY);
    chk("irq", irq, 1'b1);
    wr(`APS_IRQ_ST_OFS, 32'h8, `APS_RESP_OKAY);
    chk("irq clear", irq, 1'b0);
    x_run <= 1'b0;
    $display("busy test done");
  endtask
  task automatic t_stop();
    logic [31:0] p;
    y_run <= 1'b1;
    repeat (8) @(posedge aclk);
    cmd(16'h1, 32'h0, `APS_CMD_STOP);
    chk("y stop", y_output_stop_flag, 1'b1);
    chk("y origin", y_origin_fixed_flag, 1'b0);
    chk("x stop", x_output_stop_flag, 1'b0);
    chk("x origin", x_origin_fixed_flag, 1'b1);
    rdchk(`APS_YERR_OFS, `APS_ERR_STOP, "yerr");
    rd(`APS_YPOS_OFS, p, `APS_RESP_OKAY);
    repeat (6) @(posedge aclk);
    rdchk(`APS_YPOS_OFS, p, "ypos halted");
    y_run <= 1'b0;
    cmd(16'h1, 32'h10, `APS_CMD_PRESET);
    chk("y origin", y_origin_fixed_flag, 1'b1);
    chk("y stop kept", y_output_stop_flag, 1'b1);
    cmd(16'h1, 32'h0, `APS_CMD_CLEAR);
    rdchk(`APS_YERR_OFS, 32'h0, "yerr clear");
    chk("y stop held", y_output_stop_flag, 1'b1);
    cmd(16'h1, 32'h1, `APS_CMD_CLEAR);
    chk("y stop freed", y_output_stop_flag, 1'b0);
    cmd(16'h0, 32'h0, `APS_CMD_STOP);
    chk("x stop", x_output_stop_flag, 1'b1);
    chk("y stop", y_output_stop_flag, 1'b0);
    rdchk(`APS_XERR_OFS, `APS_ERR_STOP, "xerr");
    $display("stop test done");
  endtask
  task automatic t_bad();
    logic [15:0] sel [2];
    int          b [2];
    logic [31:0] d;
    sel[0] = 16'h0002;
    sel[1] = 16'hffff;
    b[0] = `APS_CMD_STOP;
    b[1] = `APS_CMD_PRESET;
    for (int i = 0; i < 2; i++) begin
      cmd(sel[i], 32'h5555_aaaa, b[i]);
      chk("operand err", operand_error_flag, 1'b1);
      rdchk(`APS_STATUS_OFS, 32'h0d, "status");
      rdchk(`APS_YPOS_OFS, 32'h10, "ypos");
    end
    cmd(16'h1, 32'h0, `APS_CMD_CLEAR);
    chk("operand err", operand_error_flag, 1'b0);
    rdchk(`APS_IRQ_ST_OFS, 32'h07, "irq status");
    wr(8'h3c, 32'h1, `APS_RESP_SLVERR);
    rd(8'h3c, d, `APS_RESP_SLVERR);
    chk("unmapped", d, 32'h0);
    $display("operand test done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, x_run, y_run} = 7'h0;
    {awaddr, araddr, wdata} = 48'h0;
    error_cnt = 0;
    checked = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    wr(`APS_SLOT_OFS, 32'h0, `APS_RESP_OKAY);
    t_preset();
    t_busy();
    t_stop();
    t_bad();
    summarize();
  end
endmodule
